// ===== rtl/sar_adc_pkg.sv
// Behaviour
// R1 - Control bits 7-5 pick one of eight analog inputs for the converter.
// R2 - Each conversion presets the 10-bit approximation register to 200h, then refines.
// R3 - Writing one to control bit 0 launches a conversion on the selected channel.
// R4 - Control bit 3 sets on completion and acts as interrupt pending flag.
// R5 - Result: upper eight bits in high register, lower two in low register.
// R6 - With control bit 4 set, completion raises an interrupt request.
// R7 - After completion the sequencer idles until started again.
// R8 - Each new result overwrites the old; software reads it first.
// R9 - Control bits 2-1 select the converter clock as a system clock division.
// R10 - Ten start-up clocks plus four per bit give fifty converter clocks.
// R11 - Speed 01 makes one converter clock last four system clocks.
// R12 - Only one channel is converted per conversion, held throughout.
// R13 - First trial compares against half scale, later trials use next levels.
// R14 - Software writes the channel before the conversion begins.
// R15 - Software sets shared analog pins to input mode before converting.
// R16 - At slowest speed software idles one instruction after writing start.
// R17 - Completion flag holds until software writes zero to control bit 3.
// R18 - The start bit clears itself once the conversion is accepted.
// R19 - Speed 00 selects a converter clock of system clock divided by eight.
package sar_adc_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CHAN_W   = 3;
  localparam int unsigned COUNT_W  = 6;
  localparam int unsigned IRQ_W    = 2;

  // Register offsets
  localparam logic [7:0] ADDR_CONTROL     = 8'hfa;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hfb;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'hfc;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hf0;
  localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'hf1;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hf2;

  // Control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_SPEED_LO  = 1;
  localparam int unsigned CTRL_SPEED_HI  = 2;
  localparam int unsigned CTRL_EOC_BIT   = 3;
  localparam int unsigned CTRL_IE_BIT    = 4;
  localparam int unsigned CTRL_CHAN_LO   = 5;
  localparam int unsigned CTRL_CHAN_HI   = 7;

  // Interrupt status fields
  localparam int unsigned IRQ_DONE_BIT      = 0;
  localparam int unsigned IRQ_OVERWRITE_BIT = 1;

  // Reset values and the conversion preset
  localparam logic [DATA_W-1:0]   DATA_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] SAR_PRESET = 10'h200;
  localparam logic [RESULT_W-1:0] SAR_RESET  = 10'h000;
  localparam logic [IRQ_W-1:0]    IRQ_RESET  = 2'h0;

  // Sequencer counts in converter clocks
  localparam logic [COUNT_W-1:0] STARTUP_CLOCKS = 6'h0a;
  localparam logic [COUNT_W-1:0] CLOCKS_PER_BIT = 6'h04;
  localparam logic [3:0]         MSB_INDEX      = 4'h9;

  // System clocks per converter clock for each speed code
  localparam logic [COUNT_W-1:0] DIV_SPEED_00 = 6'h08;
  localparam logic [COUNT_W-1:0] DIV_SPEED_01 = 6'h04;
  localparam logic [COUNT_W-1:0] DIV_SPEED_10 = 6'h10;
  localparam logic [COUNT_W-1:0] DIV_SPEED_11 = 6'h20;

  typedef logic [1:0] speed_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STARTUP,
    SEQ_TRIAL
  } seq_state_type;

endpackage

// ===== rtl/conv_clock_if.sv
`timescale 1ns/1ns
interface conv_clock_if import sar_adc_pkg::*; ();
  logic      run;
  speed_type speed;
  logic      tick;

  modport sequencer (
    output run,
    output speed,
    input  tick
  );

  modport divider (
    input  run,
    input  speed,
    output tick
  );
endinterface

// ===== rtl/conv_clock_divider.sv
`timescale 1ns/1ns
module conv_clock_divider import sar_adc_pkg::*; (
  // Clock and reset
  input wire logic     clk,
  input wire logic     rst_n,
  // Converter clock control
  conv_clock_if.divider clk_if
);

  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               tick_reg;
  logic               tick_next;
  logic [COUNT_W-1:0] divisor;
  logic               wrap;

  // Converter clock period
  always_comb begin
    unique case (clk_if.speed)
      // R19 - speed 00 divides by eight
      2'b00: divisor = DIV_SPEED_00;
      // R11 - speed 01 divides by four
      2'b01: divisor = DIV_SPEED_01;
      2'b10: divisor = DIV_SPEED_10;
      2'b11: divisor = DIV_SPEED_11;
    endcase
  end

  // R9 - divided converter clock enable
  assign wrap       = (count_reg == divisor - 6'h01);
  assign count_next = (!clk_if.run || wrap) ? '0 : count_reg + 6'h01;
  assign tick_next  = clk_if.run && wrap;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign clk_if.tick = tick_reg;

endmodule

// ===== rtl/sar_adc_sequencer.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module sar_adc_sequencer import sar_adc_pkg::*; (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  // Analog front end
  output logic      [CHAN_W-1:0]   channel_sel,
  output logic      [RESULT_W-1:0] trial_level,
  output logic                     convert_active,
  input  wire logic                comparator_in,
  // Interrupt
  output logic                     irq
);

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  function automatic logic [RESULT_W-1:0] bit_mask(input logic [3:0] idx);
    logic [RESULT_W-1:0] m;
    m      = '0;
    m[idx] = 1'b1;
    bit_mask = m;
  endfunction

  conv_clock_if clk_if ();

  conv_clock_divider divider_inst (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_if (clk_if)
  );

  // Control register state
  logic [CHAN_W-1:0]   chan_reg;
  logic [CHAN_W-1:0]   chan_next;
  logic                ie_reg;
  logic                ie_next;
  logic                eoc_reg;
  logic                eoc_next;
  speed_type           speed_reg;
  speed_type           speed_next;
  logic                start_reg;
  logic                start_next;

  // Sequencer state
  seq_state_type       state_reg;
  seq_state_type       state_next;
  logic [COUNT_W-1:0]  step_reg;
  logic [COUNT_W-1:0]  step_next;
  logic [3:0]          bit_reg;
  logic [3:0]          bit_next;
  logic [RESULT_W-1:0] sar_reg;
  logic [RESULT_W-1:0] sar_next;
  logic [CHAN_W-1:0]   active_chan_reg;
  logic [CHAN_W-1:0]   active_chan_next;
  speed_type           active_speed_reg;
  speed_type           active_speed_next;
  logic                busy_reg;
  logic                busy_next;

  // Results
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;

  // Interrupt block
  logic [IRQ_W-1:0]    status_reg;
  logic [IRQ_W-1:0]    status_next;
  logic [IRQ_W-1:0]    enable_reg;
  logic [IRQ_W-1:0]    enable_next;
  logic                irq_reg;
  logic                irq_next;

  // Bus read data
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic [DATA_W-1:0]   read_mux;

  // Comparator synchroniser
  logic                cmp_meta_reg;
  logic                cmp_sync_reg;

  // Decode nets
  logic                wr_control;
  logic                wr_clear;
  logic                wr_enable;
  logic                rd_control;
  logic                rd_high;
  logic                rd_low;
  logic                rd_status;
  logic                rd_enable;
  logic                is_idle;
  logic                tick;
  logic                startup_end;
  logic                bit_end;
  logic                last_bit;
  logic                accept;
  logic                comparator_keep;
  logic [3:0]          lower_bit;
  logic [RESULT_W-1:0] decided;
  logic [RESULT_W-1:0] next_try;
  logic                trial_done;
  logic                conv_done;
  logic                overwrite;
  logic [IRQ_W-1:0]    events;

  // Address decode
  assign wr_control = reg_wr && addr_hit(reg_addr, ADDR_CONTROL);
  assign wr_clear   = reg_wr && addr_hit(reg_addr, ADDR_IRQ_CLEAR);
  assign wr_enable  = reg_wr && addr_hit(reg_addr, ADDR_IRQ_ENABLE);
  assign rd_control = addr_hit(reg_addr, ADDR_CONTROL);
  assign rd_high    = addr_hit(reg_addr, ADDR_RESULT_HIGH);
  assign rd_low     = addr_hit(reg_addr, ADDR_RESULT_LOW);
  assign rd_status  = addr_hit(reg_addr, ADDR_IRQ_STATUS);
  assign rd_enable  = addr_hit(reg_addr, ADDR_IRQ_ENABLE);

  // Sequencer decode
  assign is_idle     = (state_reg == SEQ_IDLE);
  assign tick        = clk_if.tick;
  assign startup_end = (step_reg == STARTUP_CLOCKS - 6'h01);
  assign bit_end     = (step_reg == CLOCKS_PER_BIT - 6'h01);
  assign last_bit    = (bit_reg == 4'h0);

  // R3 - start bit launches from idle
  assign accept = start_reg && is_idle;

  // R13 - keep trial bit when input is at or above the level
  assign comparator_keep = cmp_sync_reg;
  assign decided         = comparator_keep ? sar_reg : (sar_reg & ~bit_mask(bit_reg));
  // Index held in range on the last bit, where the next trial is unused
  assign lower_bit       = last_bit ? 4'h0 : bit_reg - 4'h1;
  assign next_try        = decided | bit_mask(lower_bit);

  assign trial_done = (state_reg == SEQ_TRIAL) && tick && bit_end;
  assign conv_done  = trial_done && last_bit;

  // R8 - unread previous result gets replaced
  assign overwrite = conv_done && eoc_reg;

  assign events = {overwrite, conv_done};

  // R1 - channel field, free to change at any time
  assign chan_next = wr_control ? reg_wdata[CTRL_CHAN_HI:CTRL_CHAN_LO] : chan_reg;

  assign ie_next = wr_control ? reg_wdata[CTRL_IE_BIT] : ie_reg;

  // R9 - speed field
  assign speed_next = wr_control ? speed_type'(reg_wdata[CTRL_SPEED_HI:CTRL_SPEED_LO])
                                 : speed_reg;

  // R18 - start clears on acceptance; writes while busy are dropped
  assign start_next = accept ? 1'b0
                    : (wr_control && reg_wdata[CTRL_START_BIT] && is_idle) ? 1'b1
                    : start_reg;

  // R4 R17 - completion sets, only a written zero clears; set wins
  assign eoc_next = conv_done ? 1'b1
                  : (wr_control && !reg_wdata[CTRL_EOC_BIT]) ? 1'b0
                  : eoc_reg;

  // Sequencer next state
  always_comb begin
    state_next        = state_reg;
    step_next         = step_reg;
    bit_next          = bit_reg;
    sar_next          = sar_reg;
    active_chan_next  = active_chan_reg;
    active_speed_next = active_speed_reg;
    result_next       = result_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (accept) begin
          state_next        = SEQ_STARTUP;
          step_next         = '0;
          bit_next          = MSB_INDEX;
          // R2 - mid-scale preset
          sar_next          = SAR_PRESET;
          // R12 - one channel held for the whole conversion
          active_chan_next  = chan_reg;
          active_speed_next = speed_reg;
        end
      end
      SEQ_STARTUP: begin
        if (tick) begin
          // R10 - start-up clocks before the first trial
          if (startup_end) begin
            state_next = SEQ_TRIAL;
            step_next  = '0;
          end else begin
            step_next = step_reg + 6'h01;
          end
        end
      end
      SEQ_TRIAL: begin
        if (tick) begin
          // R10 - four converter clocks per bit
          if (!bit_end) begin
            step_next = step_reg + 6'h01;
          end else if (last_bit) begin
            sar_next    = decided;
            // R5 - result loaded on completion
            result_next = decided;
            // R7 - back to idle until restarted
            state_next  = SEQ_IDLE;
            step_next   = '0;
          end else begin
            // R2 - refine one bit per step
            sar_next  = next_try;
            bit_next  = bit_reg - 4'h1;
            step_next = '0;
          end
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  assign busy_next = (state_next != SEQ_IDLE);

  // Divider runs only during a conversion so each one starts phase aligned
  assign clk_if.run   = !is_idle;
  assign clk_if.speed = active_speed_reg;

  // Sticky status, clear by writing ones; a new event beats the clear
  assign status_next = (status_reg & ~(wr_clear ? reg_wdata[IRQ_W-1:0] : IRQ_RESET)) | events;
  assign enable_next = wr_enable ? reg_wdata[IRQ_W-1:0] : enable_reg;

  // R6 - request while pending and enabled
  assign irq_next = (ie_reg && eoc_reg) || (|(status_reg & enable_reg));

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    read_mux = DATA_RESET;
    if (rd_control) begin
      read_mux = {chan_reg, ie_reg, eoc_reg, speed_reg, start_reg};
    end else if (rd_high) begin
      // R5 - upper eight result bits
      read_mux = result_reg[RESULT_W-1:RESULT_W-DATA_W];
    end else if (rd_low) begin
      // R5 - lower two result bits
      read_mux = {6'h00, result_reg[1:0]};
    end else if (rd_status) begin
      read_mux = {6'h00, status_reg};
    end else if (rd_enable) begin
      read_mux = {6'h00, enable_reg};
    end
  end

  assign rdata_next = reg_rd ? read_mux : DATA_RESET;

  // Comparator is asynchronous to clk; two stages eat two system
  // clocks of the settling time at the end of each bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= comparator_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_reg  <= '0;
      ie_reg    <= 1'b0;
      eoc_reg   <= 1'b0;
      speed_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      chan_reg  <= chan_next;
      ie_reg    <= ie_next;
      eoc_reg   <= eoc_next;
      speed_reg <= speed_next;
      start_reg <= start_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg        <= SEQ_IDLE;
      step_reg         <= '0;
      bit_reg          <= '0;
      sar_reg          <= SAR_RESET;
      active_chan_reg  <= '0;
      active_speed_reg <= '0;
      busy_reg         <= 1'b0;
    end else begin
      state_reg        <= state_next;
      step_reg         <= step_next;
      bit_reg          <= bit_next;
      sar_reg          <= sar_next;
      active_chan_reg  <= active_chan_next;
      active_speed_reg <= active_speed_next;
      busy_reg         <= busy_next;
    end
  end

  // Result holds until the next completion replaces it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= SAR_RESET;
    end else begin
      result_reg <= result_next;
    end
  end

  // Status, enable and request flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= IRQ_RESET;
      enable_reg <= IRQ_RESET;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg    <= irq_next;
    end
  end

  // Read data falls back to zero after its one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= DATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // R1 - routed channel comes from the latched copy
  assign channel_sel    = active_chan_reg;
  // R13 - ladder level follows the trial register
  assign trial_level    = sar_reg;
  assign convert_active = busy_reg;
  assign irq            = irq_reg;
  assign reg_rdata      = rdata_reg;

endmodule

// ===== sim/sar_adc_sequencer_assertions.sv
`timescale 1ns/1ns
module sar_adc_sequencer_assertions import sar_adc_pkg::*; (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Register port
  input wire logic [7:0]          reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  // Analog front end
  input wire logic [CHAN_W-1:0]   channel_sel,
  input wire logic [RESULT_W-1:0] trial_level,
  input wire logic                convert_active,
  input wire logic                comparator_in,
  // Interrupt
  input wire logic                irq
);
  logic [1:0]          spd_reg;
  logic                ie_reg;
  logic [11:0]         run_cnt_reg;
  wire                 ctrl_wr  = reg_wr && reg_addr == ADDR_CONTROL;
  wire                 start_wr = ctrl_wr && reg_wdata[CTRL_START_BIT];
  wire  [5:0]          div      = spd_reg == 2'h0 ? DIV_SPEED_00 : spd_reg == 2'h1 ?
                                  DIV_SPEED_01 : spd_reg == 2'h2 ? DIV_SPEED_10 : DIV_SPEED_11;
  wire  [11:0]         exp_len  = {6'h00, div} * 12'h032;
  wire  [RESULT_W-1:0] low_bit  = trial_level & (~trial_level + 10'h001);

  // Speed only counts when latched while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spd_reg     <= 2'h0;
      ie_reg      <= 1'b0;
      run_cnt_reg <= 12'h000;
    end else begin
      if (ctrl_wr) ie_reg <= reg_wdata[CTRL_IE_BIT];
      if (ctrl_wr && !convert_active) spd_reg <= reg_wdata[CTRL_SPEED_HI:CTRL_SPEED_LO];
      run_cnt_reg <= convert_active ? run_cnt_reg + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence accept_seq;
    start_wr && !convert_active;
  endsequence
  sequence launch_seq;
    ##2 convert_active;
  endsequence

  start_launch_a: assert property (
    accept_seq |-> launch_seq) else $error("start write did not launch");
  preset_mid_a: assert property (
    $rose(convert_active) |-> trial_level == SAR_PRESET) else $error("no mid-scale preset");
  chan_hold_a: assert property (
    convert_active && $past(convert_active) |-> $stable(channel_sel))
    else $error("channel moved in conversion");
  trial_step_a: assert property (
    convert_active && $past(convert_active) && $changed(trial_level) |->
    low_bit == ($past(low_bit) >> 1)) else $error("trial step skipped a bit");
  conv_length_a: assert property (
    $fell(convert_active) |-> run_cnt_reg + 12'h004 >= exp_len && run_cnt_reg <= exp_len + 12'h004)
    else $error("conversion length wrong");
  irq_raise_a: assert property (
    $fell(convert_active) && ie_reg |-> ##[0:1] irq) else $error("no interrupt at end");
  idle_hold_a: assert property (
    !convert_active && !start_wr && !$past(start_wr) |=> !convert_active)
    else $error("left idle without start");
  rdata_quiet_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
endmodule

bind sar_adc_sequencer sar_adc_sequencer_assertions u_sar_adc_sequencer_assertions (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_sel(channel_sel),
  .trial_level(trial_level), .convert_active(convert_active),
  .comparator_in(comparator_in), .irq(irq));

// ===== sim/analog_front_model.sv
`timescale 1ns/1ns
module analog_front_model import sar_adc_pkg::*; (
  // Input levels, one per channel
  input  wire logic [7:0][RESULT_W-1:0] level_in,
  // Converter side
  input  wire logic [CHAN_W-1:0]        channel_sel,
  input  wire logic [RESULT_W-1:0]      trial_level,
  output logic                          comparator_in
);
  // channel pins serve as analog inputs only
  // mux and compare
  // Ideal comparator, no offset, so result equals the level
  assign comparator_in = level_in[channel_sel] >= trial_level;
endmodule

// ===== sim/sar_adc_sequencer_tb_top.sv
`timescale 1ns/1ns
module sar_adc_sequencer_tb_top import sar_adc_pkg::*;;
  logic                     clk;
  logic                     rst_n;
  logic [7:0]               reg_addr;
  logic [DATA_W-1:0]        reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [DATA_W-1:0]        reg_rdata;
  logic [CHAN_W-1:0]        channel_sel;
  logic [RESULT_W-1:0]      trial_level;
  logic                     convert_active;
  logic                     comparator_in;
  logic                     irq;
  logic [7:0][RESULT_W-1:0] level_in;
  int                       fail_count;
  int                       samples_checked;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  sar_adc_sequencer u_sar_adc_sequencer (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_sel(channel_sel),
    .trial_level(trial_level), .convert_active(convert_active),
    .comparator_in(comparator_in), .irq(irq));

  analog_front_model u_analog_front_model (
    .level_in(level_in), .channel_sel(channel_sel), .trial_level(trial_level),
    .comparator_in(comparator_in));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (convert_active === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Length counted from the write edge, three edges already spent
  task automatic run_conv(input logic [2:0] ch, input logic [1:0] spd, input logic ie);
    int d;
    int n;
    d = spd == 2'h0 ? 8 : spd == 2'h1 ? 4 : spd == 2'h2 ? 16 : 32;
    wr(ADDR_CONTROL, {ch, ie, 1'b0, spd, 1'b1});
    rd(ADDR_CONTROL, {ch, ie, 1'b0, spd, 1'b0});
    chk(channel_sel, ch);
    wait_idle(n);
    chk((n + 3 >= 50 * d - 1) && (n + 3 <= 50 * d + 5), 1'b1);
    @(negedge clk);
    chk(irq, ie);
    rd(ADDR_RESULT_HIGH, level_in[ch][9:2]);
    rd(ADDR_RESULT_LOW, {6'h00, level_in[ch][1:0]});
    rd(ADDR_CONTROL, {ch, ie, 1'b1, spd, 1'b0});
    chk(convert_active, 1'b0);
  endtask

  initial begin
    int n;
    rst_n           = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    fail_count      = 0;
    samples_checked = 0;
    level_in = {10'h1ff, 10'h333, 10'h200, 10'h111, 10'h000, 10'h0cc, 10'h3ff, 10'h2a5};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_RESULT_HIGH, 8'h00);
    rd(ADDR_RESULT_LOW, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(8'h10, 8'h00);
    chk(irq, 1'b0);
    $display("test reset done");
    // Odd channels, full-scale and zero levels among them
    for (int s = 0; s < 4; s++) begin
      run_conv(3'(2 * s + 1), 2'(s), 1'b1);
      repeat (40) @(negedge clk);
      rd(ADDR_CONTROL, {3'(2 * s + 1), 1'b1, 1'b1, 2'(s), 1'b0});
      wr(ADDR_CONTROL, {3'(2 * s + 1), 1'b1, 1'b0, 2'(s), 1'b0});
      rd(ADDR_CONTROL, {3'(2 * s + 1), 1'b1, 1'b0, 2'(s), 1'b0});
      chk(irq, 1'b0);
    end
    $display("test speeds done");
    run_conv(3'h0, 2'h1, 1'b0);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    rd(ADDR_IRQ_ENABLE, 8'h01);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_IRQ_CLEAR, 8'h00);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_CONTROL, 8'h0a);
    $display("test status done");
    // Second start while busy must be dropped, not queued
    // Completion flag left set, so this result counts as an overwrite
    wr(ADDR_CONTROL, 8'h4b);
    repeat (10) @(negedge clk);
    wr(ADDR_CONTROL, 8'hcb);
    @(negedge clk);
    chk(channel_sel, 3'h2);
    wait_idle(n);
    repeat (60) @(negedge clk);
    chk(convert_active, 1'b0);
    rd(ADDR_RESULT_HIGH, level_in[2][9:2]);
    rd(ADDR_IRQ_STATUS, 8'h03);
    $display("test busy start done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
